// [src/sgh_pkg.sv]
// Constants shared by the sound generator host port and dividers.
// Assumes one 40 MHz clock; all bus pins arrive asynchronously.
// How it works
// R01 - Reset pin low clears all sixteen registers; noise shift register loads seed 1.
// R02 - All generator timing comes from clk.
// R03 - Codes 000,010,101: bus idle, high impedance.
// R04 - Codes 001,100,111: latch register address.
// R05 - Code 011: drive addressed register onto bus.
// R06 - Code 110: store bus into addressed register.
// R07 - Host may use four codes, control_hi high.
// R08 - Sixteen registers, all writable; input-mode port registers read the pins.
// R09 - Ten-bit address; mismatch floats the bus.
// R10 - Extra address inputs must present 01.
// R11 - Upper bus nibble matches chip code, default 0000.
// R12 - Low address nibble latched only on match.
// R13 - Latched address holds until next latch.
// R14 - Port register access leaves sound untouched.
// R15 - Tone: clock over 16, then 12-bit period.
// R16 - Tone periods from coarse/fine register pairs.
// R17 - Noise: clock over 16, then 5-bit period.
// R18 - Each channel level is a 4-bit amplitude.
// R19 - Registers 14,15 hold port A/B data.
// R20 - Enable register: port direction and mixing.
// R21 - Fine gives low eight, coarse low four.
// R22 - Tone toggles when period counter reaches period.
package sgh_pkg;

    ////////////////////////////////////////////////////////////////
    // Bus function codes {direction, control_hi, control_lo}
    localparam logic [2:0] CODE_IDLE = 3'h0;
    localparam logic [2:0] CODE_ADDR_FROM_DATA = 3'h1;
    localparam logic [2:0] CODE_INT_ADDR_BUS = 3'h2;
    localparam logic [2:0] CODE_READ = 3'h3;
    localparam logic [2:0] CODE_BUS_ADDR = 3'h4;
    localparam logic [2:0] CODE_WRITE_PLAIN = 3'h5;
    localparam logic [2:0] CODE_WRITE_STROBE = 3'h6;
    localparam logic [2:0] CODE_IRQ_ACK = 3'h7;

    ////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [3:0] TONE_A_FINE = 4'h0;
    localparam logic [3:0] TONE_A_COARSE = 4'h1;
    localparam logic [3:0] TONE_B_FINE = 4'h2;
    localparam logic [3:0] TONE_B_COARSE = 4'h3;
    localparam logic [3:0] TONE_C_FINE = 4'h4;
    localparam logic [3:0] TONE_C_COARSE = 4'h5;
    localparam logic [3:0] NOISE_PERIOD = 4'h6;
    localparam logic [3:0] ENABLE_REG = 4'h7;
    localparam logic [3:0] AMP_A_REG = 4'h8;
    localparam logic [3:0] AMP_B_REG = 4'h9;
    localparam logic [3:0] AMP_C_REG = 4'ha;
    localparam logic [3:0] PORT_A_DATA = 4'he;
    localparam logic [3:0] PORT_B_DATA = 4'hf;

    ////////////////////////////////////////////////////////////////
    // Field positions, reset values, counts
    localparam int EN_PORT_A_OUT = 6;
    localparam int EN_PORT_B_OUT = 7;
    localparam int EN_NOISE_LSB = 3;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] EXTRA_ADDR_MATCH = 2'h1;
    localparam logic [3:0] CHIP_CODE_DEFAULT = 4'h0;
    localparam int PRESCALE_DIV = 16;
    localparam logic [16:0] LFSR_SEED = 17'h00001;

endpackage : sgh_pkg

// [src/sgh_sync.sv]
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs asynchronous to clk.
`timescale 1ns/1ps
module sgh_sync
    import sgh_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] filtered
);

    // Synchroniser stages; stage one feeds stage two only
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    ////////////////////////////////////////////////////////////////
    // Shift chain
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
        end
        else
        begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Accept a bit once stages two and three agree
    always_ff @(posedge clk)
    begin
        if (srst)
            filtered <= RESET_VAL;
        else
            filtered <= (filtered & (stage2 ^ stage3)) | (stage3 & ~(stage2 ^ stage3));
    end

endmodule : sgh_sync

// [src/sgh_divider.sv]
// Programmable period divider producing a square wave.
// Assumes a one-cycle tick at clk/16 from the prescaler.
`timescale 1ns/1ps
module sgh_divider
    import sgh_pkg::*;
#(
    parameter int WIDTH = 12
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic tick,
    input wire logic [WIDTH-1:0] period,
    output logic wave,
    output logic pulse
);

    // Period counter
    logic [WIDTH-1:0] count;
    // Zero period behaves as one
    logic reached;

    assign reached = ({1'b0, count} + {{WIDTH{1'b0}}, 1'b1}) >= {1'b0, period};

    ////////////////////////////////////////////////////////////////
    // Count ticks, toggle on reaching period
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            count <= '0;
            wave <= 1'b0;
            pulse <= 1'b0;
        end
        else
        begin
            pulse <= 1'b0;
            if (tick)
            begin
                if (reached) // R22
                begin
                    count <= '0;
                    wave <= ~wave;
                    pulse <= 1'b1;
                end
                else
                    count <= count + 1'b1;
            end
        end
    end

endmodule : sgh_divider

// [src/sgh_top.sv]
// Host bus front end, register array, tone and noise dividers.
// Assumes all pins asynchronous; bus pins are three signals each.
`timescale 1ns/1ps
module sgh_top
    import sgh_pkg::*;
#(
    parameter logic [3:0] CHIP_CODE = CHIP_CODE_DEFAULT,
    parameter int TONE_W = 12,
    parameter int NOISE_W = 5
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic resetN,
    input wire logic busDirection,
    input wire logic busControlHi,
    input wire logic busControlLo,
    input wire logic extraAddrLo,
    input wire logic extraAddrHiN,
    input wire logic [7:0] muxBusIn,
    output logic [7:0] muxBusOut,
    output logic [7:0] muxBusOe,
    input wire logic [7:0] portAIn,
    output logic [7:0] portAOut,
    output logic [7:0] portAOe,
    input wire logic [7:0] portBIn,
    output logic [7:0] portBOut,
    output logic [7:0] portBOe,
    output logic [2:0] toneWave,
    output logic noiseBit,
    output logic [2:0] chanMix,
    output logic [3:0] ampA,
    output logic [3:0] ampB,
    output logic [3:0] ampC
);

    ////////////////////////////////////////////////////////////////
    // Declarations
    // Filtered bus pins
    logic [13:0] busPins;
    logic [2:0] busCode;
    logic [7:0] busData;
    logic addrLo;
    logic addrHiN;
    logic chipResetN;
    // Filtered port pins
    logic [15:0] portPins;
    // Register array
    logic [7:0] regFile [16];
    // Latched register index and chip select
    logic [3:0] regAddr;
    logic chipSel;
    // Decoded bus functions
    logic isLatch;
    logic isRead;
    logic isWrite;
    logic addrMatch;
    // Combined register clear
    logic clearAll;
    // Data for a read
    logic [7:0] readData;
    // Prescaler
    logic [3:0] prescale;
    logic tick;
    // Divider outputs
    logic [2:0] toneRaw;
    logic noisePulse;
    // Noise shift register
    logic [16:0] lfsr;

    ////////////////////////////////////////////////////////////////
    // Functions
    // Fine gives low eight, coarse low four
    function automatic logic [11:0] tonePeriod(input logic [7:0] coarse, input logic [7:0] fine);
        tonePeriod = {coarse[3:0], fine}; // R21
    endfunction : tonePeriod

    // Latch codes
    function automatic logic latchCode(input logic [2:0] code);
        latchCode = (code == CODE_ADDR_FROM_DATA) || (code == CODE_BUS_ADDR) || (code == CODE_IRQ_ACK);
    endfunction : latchCode

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers
    // Bus control, extra address, reset and data lines
    sgh_sync #(.WIDTH(14), .RESET_VAL(14'h2000)) u_busSync (
        .clk(clk),
        .srst(srst),
        .pinIn({resetN, extraAddrHiN, extraAddrLo, busDirection, busControlHi, busControlLo, muxBusIn}),
        .filtered(busPins)
    );

    // Port pins, only read back
    sgh_sync #(.WIDTH(16), .RESET_VAL(16'hffff)) u_portSync (
        .clk(clk),
        .srst(srst),
        .pinIn({portBIn, portAIn}),
        .filtered(portPins)
    );

    assign chipResetN = busPins[13];
    assign addrHiN = busPins[12];
    assign addrLo = busPins[11];
    // Function code {direction, control_hi, control_lo}
    assign busCode = busPins[10:8];
    assign busData = busPins[7:0];

    ////////////////////////////////////////////////////////////////
    // Bus function decode
    // Host with control_hi tied high uses four codes only
    assign isLatch = latchCode(busCode); // R04 R07
    assign isRead = busCode == CODE_READ; // R05
    assign isWrite = busCode == CODE_WRITE_STROBE; // R06
    // Ten-bit address match
    assign addrMatch = ({addrHiN, addrLo} == EXTRA_ADDR_MATCH) // R10
        && (busData[7:4] == CHIP_CODE); // R09 R11
    // Reset pin low or system reset
    assign clearAll = srst || !chipResetN; // R01

    ////////////////////////////////////////////////////////////////
    // Address latch and chip select
    always_ff @(posedge clk)
    begin
        if (clearAll)
        begin
            regAddr <= 4'h0;
            chipSel <= 1'b0;
        end
        else if (isLatch)
        begin
            // Low nibble only on a valid match
            if (addrMatch)
                regAddr <= busData[3:0]; // R12
            // Mismatch deselects the chip
            chipSel <= addrMatch; // R09
        end
        // Otherwise the index holds
    end // R13

    ////////////////////////////////////////////////////////////////
    // Register array writes
    always_ff @(posedge clk)
    begin
        if (clearAll)
        begin
            for (int i = 0; i < 16; i++)
                regFile[i] <= REG_RESET; // R01
        end
        else if (isWrite && chipSel)
            regFile[regAddr] <= busData; // R06 R08
    end

    ////////////////////////////////////////////////////////////////
    // Read data selection
    always_comb
    begin
        readData = regFile[regAddr]; // R08
        // Input-mode ports read the pins
        if (regAddr == PORT_A_DATA && !regFile[ENABLE_REG][EN_PORT_A_OUT])
            readData = portPins[7:0]; // R19
        if (regAddr == PORT_B_DATA && !regFile[ENABLE_REG][EN_PORT_B_OUT])
            readData = portPins[15:8]; // R19
    end

    ////////////////////////////////////////////////////////////////
    // Bus drivers
    always_ff @(posedge clk)
    begin
        if (clearAll)
        begin
            muxBusOut <= 8'h00;
            muxBusOe <= 8'h00;
        end
        else if (isRead && chipSel)
        begin
            // Drive addressed register
            muxBusOut <= readData; // R05
            muxBusOe <= 8'hff;
        end
        else
        begin
            // Idle, latch, write or deselect float
            muxBusOut <= 8'h00;
            muxBusOe <= 8'h00; // R03 R09
        end
    end

    ////////////////////////////////////////////////////////////////
    // Parallel port drivers, independent of sound
    always_ff @(posedge clk)
    begin
        if (clearAll)
        begin
            portAOut <= 8'h00;
            portAOe <= 8'h00;
            portBOut <= 8'h00;
            portBOe <= 8'h00;
        end
        else
        begin
            portAOut <= regFile[PORT_A_DATA]; // R14 R19
            portAOe <= {8{regFile[ENABLE_REG][EN_PORT_A_OUT]}}; // R20
            portBOut <= regFile[PORT_B_DATA]; // R19
            portBOe <= {8{regFile[ENABLE_REG][EN_PORT_B_OUT]}}; // R20
        end
    end

    ////////////////////////////////////////////////////////////////
    // Clock over sixteen prescaler
    always_ff @(posedge clk)
    begin
        if (clearAll)
            prescale <= 4'h0;
        else
            prescale <= prescale + 4'h1; // R02
    end

    assign tick = prescale == 4'(PRESCALE_DIV - 1); // R15 R17

    ////////////////////////////////////////////////////////////////
    // Tone dividers, one per channel
    sgh_divider #(.WIDTH(TONE_W)) u_toneA (
        .clk(clk),
        .srst(clearAll),
        .tick(tick),
        .period(tonePeriod(regFile[TONE_A_COARSE], regFile[TONE_A_FINE])), // R16
        .wave(toneRaw[0]),
        .pulse()
    );

    sgh_divider #(.WIDTH(TONE_W)) u_toneB (
        .clk(clk),
        .srst(clearAll),
        .tick(tick),
        .period(tonePeriod(regFile[TONE_B_COARSE], regFile[TONE_B_FINE])), // R16
        .wave(toneRaw[1]),
        .pulse()
    );

    sgh_divider #(.WIDTH(TONE_W)) u_toneC (
        .clk(clk),
        .srst(clearAll),
        .tick(tick),
        .period(tonePeriod(regFile[TONE_C_COARSE], regFile[TONE_C_FINE])), // R16
        .wave(toneRaw[2]),
        .pulse()
    );

    ////////////////////////////////////////////////////////////////
    // Noise divider and shift register
    sgh_divider #(.WIDTH(NOISE_W)) u_noise (
        .clk(clk),
        .srst(clearAll),
        .tick(tick),
        .period(regFile[NOISE_PERIOD][NOISE_W-1:0]), // R17
        .wave(),
        .pulse(noisePulse)
    );

    // Shift once per noise period
    always_ff @(posedge clk)
    begin
        if (clearAll)
            lfsr <= LFSR_SEED;
        else if (noisePulse)
            lfsr <= {lfsr[0] ^ lfsr[3], lfsr[16:1]};
    end

    ////////////////////////////////////////////////////////////////
    // Outputs: tones, noise, mix, levels
    always_ff @(posedge clk)
    begin
        if (clearAll)
        begin
            toneWave <= 3'h0;
            noiseBit <= 1'b0;
            chanMix <= 3'h0;
            ampA <= 4'h0;
            ampB <= 4'h0;
            ampC <= 4'h0;
        end
        else
        begin
            toneWave <= toneRaw;
            noiseBit <= lfsr[0];
            // Enable bit low lets a source through
            for (int c = 0; c < 3; c++)
                chanMix[c] <= (toneRaw[c] | regFile[ENABLE_REG][c])
                    & (lfsr[0] | regFile[ENABLE_REG][EN_NOISE_LSB + c]); // R20
            ampA <= regFile[AMP_A_REG][3:0]; // R18
            ampB <= regFile[AMP_B_REG][3:0]; // R18
            ampC <= regFile[AMP_C_REG][3:0]; // R18
        end
    end

    ////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Register clear on reset pin
    property p_pin_clear;
        !chipResetN |=> regFile[TONE_A_FINE] == 8'h00 && !chipSel && muxBusOe == 8'h00;
    endproperty
    a_pin_clear: assert property (p_pin_clear) else $error("reset pin did not clear"); // R01

    // Idle codes float the bus
    property p_idle_float;
        (busCode == CODE_IDLE || busCode == CODE_INT_ADDR_BUS || busCode == CODE_WRITE_PLAIN)
            |=> muxBusOe == 8'h00;
    endproperty
    a_idle_float: assert property (p_idle_float) else $error("bus driven while idle"); // R03

    // Read drives addressed data
    property p_read_drive;
        isRead && chipSel && chipResetN |=> muxBusOe == 8'hff && muxBusOut == $past(readData);
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read data not driven"); // R05

    // Write stores bus data
    property p_write_store;
        isWrite && chipSel && chipResetN |=> regFile[$past(regAddr)] == $past(busData);
    endproperty
    a_write_store: assert property (p_write_store) else $error("write not stored"); // R06

    // Matched latch captures index
    property p_latch_match;
        isLatch && addrMatch && chipResetN |=> regAddr == $past(busData[3:0]) && chipSel;
    endproperty
    a_latch_match: assert property (p_latch_match) else $error("address not latched"); // R12

    // Mismatch deselects, keeps index
    property p_latch_miss;
        isLatch && !addrMatch && chipResetN |=> !chipSel && $stable(regAddr) ##1 muxBusOe == 8'h00;
    endproperty
    a_latch_miss: assert property (p_latch_miss) else $error("mismatch not rejected"); // R09

    // Index holds without latch
    property p_addr_hold;
        !isLatch && chipResetN |=> $stable(regAddr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address changed"); // R13

    // Prescaler tick every sixteen cycles
    property p_tick_period;
        disable iff (clearAll) tick |-> ##16 tick;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("prescale not sixteen"); // R15

    // Level follows amplitude register
    property p_amp_level;
        chipResetN ##1 chipResetN |-> ampA == $past(regFile[AMP_A_REG][3:0]);
    endproperty
    a_amp_level: assert property (p_amp_level) else $error("level mismatch"); // R18

    // Scenario coverage
    c_read: cover property (isRead && chipSel ##1 muxBusOe == 8'hff);
    c_write: cover property (isWrite && chipSel);
    c_miss: cover property (isLatch && !addrMatch);
    c_tone: cover property ($rose(toneWave[0]));

endmodule : sgh_top

// [verification/sgh_host_model.sv]
// Host processor model driving the sound generator bus pins.
// Assumes the bench calls its tasks at a falling clock edge.
`timescale 1ns/1ps
module sgh_host_model
    import sgh_pkg::*;
(
    input wire logic clk,
    output logic busDirection,
    output logic busControlHi,
    output logic busControlLo,
    output logic extraAddrLo,
    output logic extraAddrHiN,
    output logic [7:0] muxBusIn,
    input wire logic [7:0] muxBusOut,
    input wire logic [7:0] muxBusOe
);
    ////////////////////////////////////////////////////////////////
    logic [7:0] hostVal; // Last value placed by host
    logic hostDrive; // Host drives the bus
    // Wire level: device, host, or inverted remnant once released
    assign muxBusIn = (muxBusOe & muxBusOut) | (~muxBusOe & (hostDrive ? hostVal : ~hostVal));
    // Idle with control_hi high, address pins selecting
    initial
    begin
        {busDirection, busControlHi, busControlLo} = CODE_INT_ADDR_BUS;
        extraAddrLo = 1'b1;
        extraAddrHiN = 1'b0;
        hostVal = 8'h00;
        hostDrive = 1'b1;
    end
    // Sets the two extra address pins
    task automatic setSel(input logic lo, input logic hiN);
        extraAddrLo = lo;
        extraAddrHiN = hiN;
    endtask : setSel
    // One bus cycle: data settles first, code held, then idle again
    task automatic op(input logic [2:0] code, input logic [7:0] data, input logic drive,
        output logic [7:0] got, output logic [7:0] oe);
        @(negedge clk);
        hostVal = data;
        hostDrive = drive;
        repeat (6) @(negedge clk);
        {busDirection, busControlHi, busControlLo} = code;
        repeat (6) @(negedge clk);
        got = muxBusIn;
        oe = muxBusOe;
        {busDirection, busControlHi, busControlLo} = CODE_INT_ADDR_BUS;
        repeat (6) @(negedge clk);
    endtask : op
endmodule : sgh_host_model

// [verification/tb_top.sv]
// Self-checking bench for the sound generator host port and dividers.
// Assumes the host model file is compiled before this one.
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top
    import sgh_pkg::*;
;
    ////////////////////////////////////////////////////////////////
    logic clk, srst, resetN;
    logic busDirection, busControlHi, busControlLo, extraAddrLo, extraAddrHiN;
    logic [7:0] muxBusIn, muxBusOut, muxBusOe;
    logic [7:0] portAIn, portAOut, portAOe, portBIn, portBOut, portBOe;
    logic [2:0] toneWave, chanMix;
    logic noiseBit;
    logic [3:0] waves; // Noise bit above the three tones
    assign waves = {noiseBit, toneWave};
    logic [3:0] ampA, ampB, ampC;
    int fails, num_checks, cycles;
    logic [7:0] shadow [16]; // Expected register contents
    logic [7:0] g, o; // Last bus sample and enable
    logic [2:0] latchCodes [3] = '{CODE_ADDR_FROM_DATA, CODE_BUS_ADDR, CODE_IRQ_ACK};
    logic [2:0] idleCodes [3] = '{CODE_IDLE, CODE_INT_ADDR_BUS, CODE_WRITE_PLAIN};
    // Bad selects: {extraAddrLo, extraAddrHiN, upper nibble}
    logic [5:0] badSel [3] = '{6'b000000, 6'b110000, 6'b100001};

    ////////////////////////////////////////////////////////////////
    sgh_top u_sgh_top (.clk(clk), .srst(srst), .resetN(resetN), .busDirection(busDirection),
        .busControlHi(busControlHi), .busControlLo(busControlLo), .extraAddrLo(extraAddrLo),
        .extraAddrHiN(extraAddrHiN), .muxBusIn(muxBusIn), .muxBusOut(muxBusOut), .muxBusOe(muxBusOe),
        .portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe), .portBIn(portBIn),
        .portBOut(portBOut), .portBOe(portBOe), .toneWave(toneWave), .noiseBit(noiseBit),
        .chanMix(chanMix), .ampA(ampA), .ampB(ampB), .ampC(ampC));
    sgh_host_model u_sgh_host_model (.clk(clk), .busDirection(busDirection),
        .busControlHi(busControlHi), .busControlLo(busControlLo), .extraAddrLo(extraAddrLo),
        .extraAddrHiN(extraAddrHiN), .muxBusIn(muxBusIn), .muxBusOut(muxBusOut), .muxBusOe(muxBusOe));

    ////////////////////////////////////////////////////////////////
    // 40 MHz clock
    always #12.5 clk = ~clk;
    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fails++;
            test_done();
        end
    end
    // Verdict and end of run
    task automatic test_done();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    // One raw bus cycle
    task automatic op(input logic [2:0] c, input logic [7:0] d, input logic dr);
        u_sgh_host_model.op(c, d, dr, g, o);
    endtask : op
    // Register access with a fresh address latch
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        op(CODE_IRQ_ACK, {CHIP_CODE_DEFAULT, a}, 1'b1);
        op(CODE_WRITE_STROBE, d, 1'b1);
        shadow[a] = d;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        op(CODE_IRQ_ACK, {CHIP_CODE_DEFAULT, a}, 1'b1);
        op(CODE_READ, 8'h00, 1'b0);
        `CHK(o, 8'hff)
        `CHK(g, e)
    endtask : rd
    // Clocks between two changes of one tone output or the noise bit
    task automatic tone(input int ch, input int exp);
        logic prev;
        int n;
        for (int k = 0; k < 2; k++)
        begin
            prev = waves[ch];
            n = 0;
            while (waves[ch] === prev && n < 20000)
            begin
                @(negedge clk);
                n++;
            end
        end
        `CHK(n, exp)
    endtask : tone

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        clk = 1'b0;
        srst = 1'b1;
        resetN = 1'b1;
        portAIn = 8'h5a;
        portBIn = 8'ha5;
        fails = 0;
        num_checks = 0;
        cycles = 0;
        for (int i = 0; i < 16; i++)
            shadow[i] = 8'h00;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        repeat (5) @(negedge clk);
        // Reset contents, ports start as inputs
        for (int i = 0; i < 14; i++)
            rd(4'(i), 8'h00);
        rd(PORT_A_DATA, 8'h5a);
        // Every register written; all but port A read back
        for (int i = 0; i < 16; i++)
            wr(4'(i), 8'(i * 19 + 1));
        for (int i = 0; i < 14; i++)
            rd(4'(i), shadow[i]);
        rd(PORT_A_DATA, 8'h5a);
        rd(PORT_B_DATA, shadow[15]);
        `CHK(portBOut, shadow[15])
        `CHK(portBOe, 8'hff)
        `CHK(portAOe, 8'h00)
        `CHK(ampA, shadow[8][3:0])
        `CHK(ampB, shadow[9][3:0])
        `CHK(ampC, shadow[10][3:0])
        // Repeated access without a new address
        op(CODE_WRITE_STROBE, 8'h3c, 1'b1);
        op(CODE_READ, 8'h00, 1'b0);
        `CHK(g, 8'h3c)
        op(CODE_READ, 8'h00, 1'b0);
        `CHK(g, 8'h3c)
        `CHK(portBOut, 8'h3c)
        // Each latch code
        for (int j = 0; j < 3; j++)
        begin
            op(latchCodes[j], {CHIP_CODE_DEFAULT, 4'(8 + j)}, 1'b1);
            op(CODE_WRITE_STROBE, 8'(8'h40 + j), 1'b1);
            rd(4'(8 + j), 8'(8'h40 + j));
        end
        // Each idle code floats the bus and stores nothing
        op(CODE_IRQ_ACK, {CHIP_CODE_DEFAULT, 4'h1}, 1'b1);
        for (int j = 0; j < 3; j++)
        begin
            op(idleCodes[j], 8'hee, 1'b1);
            `CHK(o, 8'h00)
        end
        rd(4'h1, shadow[1]);
        // Wrong high-order address
        for (int j = 0; j < 3; j++)
        begin
            u_sgh_host_model.setSel(badSel[j][5], badSel[j][4]);
            op(CODE_IRQ_ACK, {badSel[j][3:0], 4'h4}, 1'b1);
            op(CODE_WRITE_STROBE, 8'hdd, 1'b1);
            op(CODE_READ, 8'h00, 1'b0);
            `CHK(o, 8'h00)
            u_sgh_host_model.setSel(1'b1, 1'b0);
        end
        rd(4'h4, shadow[4]);
        rd(4'h1, shadow[1]);
        // Reset pin clears the array
        resetN = 1'b0;
        repeat (8) @(negedge clk);
        resetN = 1'b1;
        repeat (8) @(negedge clk);
        `CHK(noiseBit, 1'b1)
        // Period 0 acts as 1: zero run of sixteen shifts, 16 clocks each
        tone(3, 256);
        for (int i = 0; i < 8; i++)
            rd(4'(i), 8'h00);
        `CHK(portBOe, 8'h00)
        // Tone periods: A=3, B=256, C=5
        wr(TONE_A_FINE, 8'h03);
        wr(TONE_A_COARSE, 8'hf0);
        wr(TONE_B_FINE, 8'h00);
        wr(TONE_B_COARSE, 8'h01);
        wr(TONE_C_FINE, 8'h05);
        tone(0, 48);
        tone(1, 4096);
        tone(2, 80);
        // Port register traffic leaves tone untouched
        wr(PORT_A_DATA, 8'h77);
        `CHK(portAOut, 8'h77)
        tone(0, 48);
        // Mixer: every source off, then tone only
        wr(ENABLE_REG, 8'h3f);
        `CHK(chanMix, 3'h7)
        wr(ENABLE_REG, 8'h38);
        `CHK(chanMix, toneWave)
        test_done();
    end
endmodule : tb_top
